/* hdl/pisr_link_if.sv */
// link between the package resolver and the platform controller
`timescale 1ns/10ps
interface pisr_link_if;
    pisr_pkg::pisr_pstate_t pkg_state;   // current package state
    logic crystal_off;                   // package asks to stop the crystal clock
    pisr_pkg::pisr_pstate_t ltr_cap;     // deepest state latency tolerance permits
    logic hold_high;                     // platform asks to hold a shallower state
    pisr_pkg::pisr_pstate_t hold_cap;    // state to hold while hold_high is set
    logic mem_break;                     // memory access or snoop break, one cycle
    logic disp_off;                      // display powered off
    logic disp_psr;                      // display in self-refresh
    logic single_panel;                  // single embedded panel configuration
    logic panel_psr_cap;                 // panel supports self-refresh
    logic vr_deep;                       // all regulators deepest or low-power mode
    logic xtal_stop_ok;                  // platform lets the crystal clock stop

    modport dev (
        output pkg_state, crystal_off,
        input ltr_cap, hold_high, hold_cap, mem_break, disp_off, disp_psr,
        input single_panel, panel_psr_cap, vr_deep, xtal_stop_ok
    );

    modport plat (
        input pkg_state, crystal_off,
        output ltr_cap, hold_high, hold_cap, mem_break, disp_off, disp_psr,
        output single_panel, panel_psr_cap, vr_deep, xtal_stop_ok
    );
endinterface

/* hdl/pisr_min_req.sv */
// lowest idle request among all cores
`timescale 1ns/10ps
module pisr_min_req #(
    parameter int N_CORES = pisr_pkg::N_CORES_DEF
) (
    input wire logic [pisr_pkg::CR_W*N_CORES-1:0] core_req_i, // packed per-core requests
    output logic [pisr_pkg::CR_W-1:0] min_req_o               // numerically lowest request
);
    logic [pisr_pkg::CR_W-1:0] chain [N_CORES];

    assign chain[0] = core_req_i[pisr_pkg::CR_W-1:0];

    genvar g;
    generate
        for (g = 1; g < N_CORES; g = g + 1) begin : g_min
            wire [pisr_pkg::CR_W-1:0] req_g = core_req_i[pisr_pkg::CR_W*g +: pisr_pkg::CR_W];
            assign chain[g] = (req_g < chain[g-1]) ? req_g : chain[g-1];
        end
    endgenerate

    assign min_req_o = chain[N_CORES-1];
endmodule

/* hdl/pisr_pkg.sv */
// shared types and constants for the package idle state resolver
package pisr_pkg;

    // package idle states, shallow to deep; order matters for min/max compares
    typedef enum logic [2:0] {
        PS_C0,
        PS_C2,
        PS_C3,
        PS_C6,
        PS_C8,
        PS_C10
    } pisr_pstate_t;

    // per-core idle request encoding
    localparam int CR_W = 3;
    localparam logic [2:0] CR_C0 = 3'h0;
    localparam logic [2:0] CR_C1 = 3'h1;
    localparam logic [2:0] CR_C6 = 3'h2;
    localparam logic [2:0] CR_C8 = 3'h3;
    localparam logic [2:0] CR_C10 = 3'h4;

    // reset values
    localparam pisr_pstate_t PSTATE_RST = PS_C0;
    localparam pisr_pstate_t LTR_CAP_RST = PS_C0;

    // default core count
    localparam int N_CORES_DEF = 4;
    localparam int CORE_ID_W_DEF = 2;

endpackage

/* hdl/pisr_platform.sv */
// platform controller end: grants package depth and raises memory breaks
`timescale 1ns/10ps
module pisr_platform (
    input wire logic ref_clk_i,                        // 50 MHz clock
    input wire logic nrst_i,                           // async reset, active low
    input wire pisr_pkg::pisr_pstate_t ltr_cap_i,      // deepest state devices tolerate
    input wire logic hold_high_i,                      // keep package shallower
    input wire pisr_pkg::pisr_pstate_t hold_cap_i,     // state to hold
    input wire logic mem_req_i,                        // memory access or snoop, pulse
    input wire logic disp_off_i,                       // display off
    input wire logic disp_psr_i,                       // display in self-refresh
    input wire logic single_panel_i,                   // single embedded panel
    input wire logic panel_psr_cap_i,                  // panel supports self-refresh
    input wire logic vr_deep_i,                        // regulators deepest or low-power
    input wire logic xtal_stop_ok_i,                   // crystal may be stopped
    output pisr_pkg::pisr_pstate_t pkg_state_o,        // observed package state
    output logic mem_grant_o,                          // memory request serviced, pulse
    output logic xtal_stopped_o,                       // crystal clock stopped
    pisr_link_if.plat link                             // package side
);
    pisr_pkg::pisr_pstate_t ltr_cap;
    pisr_pkg::pisr_pstate_t hold_cap;
    pisr_pkg::pisr_pstate_t pkg_state;
    logic hold_high;
    logic mem_break;
    logic mem_pend;
    logic mem_grant;
    logic xtal_stopped;
    logic [5:0] status;

    // memory path is open in C0 and C2 only
    wire mem_open = (link.pkg_state <= pisr_pkg::PS_C2);
    wire next_grant = mem_pend && mem_open;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ltr_cap <= pisr_pkg::LTR_CAP_RST;
            hold_cap <= pisr_pkg::PSTATE_RST;
            hold_high <= 1'b0;
            status <= 6'h00;
        end else begin
            ltr_cap <= ltr_cap_i;
            hold_cap <= hold_cap_i;
            hold_high <= hold_high_i;
            status <= {disp_off_i, disp_psr_i, single_panel_i, panel_psr_cap_i,
                       vr_deep_i, xtal_stop_ok_i};
        end
    end

    // pending request survives until the package opens memory; set wins
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_break <= 1'b0;
            mem_pend <= 1'b0;
            mem_grant <= 1'b0;
        end else begin
            mem_break <= mem_req_i && !mem_pend && !mem_open;
            mem_pend <= mem_req_i || (mem_pend && !next_grant);
            mem_grant <= next_grant;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pkg_state <= pisr_pkg::PSTATE_RST;
            xtal_stopped <= 1'b0;
        end else begin
            pkg_state <= link.pkg_state;
            xtal_stopped <= link.crystal_off && xtal_stop_ok_i;
        end
    end

    assign link.ltr_cap = ltr_cap;
    assign link.hold_cap = hold_cap;
    assign link.hold_high = hold_high;
    assign link.mem_break = mem_break;
    assign link.disp_off = status[5];
    assign link.disp_psr = status[4];
    assign link.single_panel = status[3];
    assign link.panel_psr_cap = status[2];
    assign link.vr_deep = status[1];
    assign link.xtal_stop_ok = status[0];
    assign pkg_state_o = pkg_state;
    assign mem_grant_o = mem_grant;
    assign xtal_stopped_o = xtal_stopped;
endmodule

/* hdl/pisr_resolver.sv */
// package idle state resolver: the package end of the link
// What this block does
// - six package states: C0 C2 C3 C6 C8 C10
// - request equals lowest core request
// - resolve from core states and platform status
// - platform refusal keeps package shallower than cores
// - deep state changes skip package C0
// - auto-demotion may cap the package state
// - core break leaves state, wakes target core
// - unmasked core break forces package C0
// - masked core break returns to previous state
// - memory break without hold returns previous state
// - memory break with hold stays shallower
// - any core in C0 means package C0
// - C2 only as transit or constrained state
// - C2 when deep requested but constraints block
// - C3 needs deep cores, graphics off, tolerance
// - C6 stops base clock, lets regulators drop
// - C8 needs all cores C8 and tolerance
// - all cores C8: flush cache once, unpower
// - C10 needs display, regulators, crystal conditions
// - self-refresh counts only for single capable panel
`timescale 1ns/10ps
module pisr_resolver #(
    parameter int N_CORES = pisr_pkg::N_CORES_DEF,
    parameter int CORE_ID_W = pisr_pkg::CORE_ID_W_DEF
) (
    input wire logic ref_clk_i,                                // 50 MHz clock
    input wire logic nrst_i,                                   // async reset, active low
    input wire logic [pisr_pkg::CR_W*N_CORES-1:0] core_req_i,  // per-core idle requests
    input wire logic gfx_pd_i,                                 // graphics powered down
    input wire logic timer_near_i,                             // timer event imminent
    input wire logic autodemote_en_i,                          // auto-demotion enabled
    input wire pisr_pkg::pisr_pstate_t autodemote_cap_i,       // heuristic deepest state
    input wire logic core_break_i,                             // core break event, pulse
    input wire logic [CORE_ID_W-1:0] break_core_i,             // target core of the break
    input wire logic break_masked_i,                           // break event is masked
    output pisr_pkg::pisr_pstate_t pkg_state_o,                // current package state
    output logic [N_CORES-1:0] core_wake_o,                    // break forwarded to core
    output logic wake_masked_o,                                // forwarded break was masked
    output logic mem_sr_o,                                     // memory self-refresh
    output logic bclk_off_o,                                   // base clock stopped
    output logic vr_reduce_o,                                  // regulator voltage reduction
    output logic llc_flush_o,                                  // single-step cache flush
    output logic llc_off_o,                                    // cache supply removed
    pisr_link_if.dev link                                      // platform side
);
    pisr_pkg::pisr_pstate_t state;
    pisr_pkg::pisr_pstate_t prev_state;
    pisr_pkg::pisr_pstate_t next_state;
    logic returning;
    logic force_c0;
    logic [N_CORES-1:0] core_wake;
    logic wake_masked;
    logic mem_sr;
    logic bclk_off;
    logic vr_reduce;
    logic llc_flush;
    logic llc_off;
    logic crystal_off;

    function automatic pisr_pkg::pisr_pstate_t pmin(input pisr_pkg::pisr_pstate_t a,
                                                    input pisr_pkg::pisr_pstate_t b);
        pmin = (a < b) ? a : b;
    endfunction

    function automatic pisr_pkg::pisr_pstate_t req_to_pkg(input logic [2:0] req);
        if (req >= pisr_pkg::CR_C10) begin
            req_to_pkg = pisr_pkg::PS_C10;
        end else if (req == pisr_pkg::CR_C8) begin
            req_to_pkg = pisr_pkg::PS_C8;
        end else if (req == pisr_pkg::CR_C6) begin
            req_to_pkg = pisr_pkg::PS_C6;
        end else begin
            req_to_pkg = pisr_pkg::PS_C0;
        end
    endfunction

    // lowest request across cores
    wire [pisr_pkg::CR_W-1:0] min_req;

    pisr_min_req #(
        .N_CORES(N_CORES)
    ) u_min (
        .core_req_i(core_req_i),
        .min_req_o(min_req)
    );

    // core C0/C1 or active graphics pins the package to C0
    wire shallow = (min_req < pisr_pkg::CR_C6) || !gfx_pd_i;
    wire pisr_pkg::pisr_pstate_t core_cap = req_to_pkg(min_req);

    // self-refresh only counts for one embedded panel that supports it
    wire disp_ok = link.disp_off ||
                   (link.disp_psr && link.single_panel && link.panel_psr_cap);
    wire c10_ok = disp_ok && link.vr_deep && link.xtal_stop_ok;

    wire pisr_pkg::pisr_pstate_t cap_c10 =
        (core_cap == pisr_pkg::PS_C10 && !c10_ok) ? pisr_pkg::PS_C8 : core_cap;
    // latency tolerance from the platform limits the depth
    wire pisr_pkg::pisr_pstate_t cap_ltr = pmin(cap_c10, link.ltr_cap);
    wire pisr_pkg::pisr_pstate_t cap_tmr =
        timer_near_i ? pmin(cap_ltr, pisr_pkg::PS_C2) : cap_ltr;
    wire pisr_pkg::pisr_pstate_t cap_dem =
        autodemote_en_i ? pmin(cap_tmr, autodemote_cap_i) : cap_tmr;
    wire pisr_pkg::pisr_pstate_t cap_hold =
        link.hold_high ? pmin(cap_dem, link.hold_cap) : cap_dem;
    wire pisr_pkg::pisr_pstate_t cap_ret =
        returning ? pmin(cap_hold, prev_state) : cap_hold;
    // deep requests with every deeper state blocked still settle in C2
    wire pisr_pkg::pisr_pstate_t cap_floor =
        (cap_ret < pisr_pkg::PS_C2) ? pisr_pkg::PS_C2 : cap_ret;
    wire pisr_pkg::pisr_pstate_t target =
        (shallow || force_c0) ? pisr_pkg::PS_C0 : cap_floor;

    wire in_c0 = (state == pisr_pkg::PS_C0);
    wire deep_now = (state > pisr_pkg::PS_C2);
    wire break_now = (core_break_i || link.mem_break) && !in_c0;
    wire ret_set = ((core_break_i && break_masked_i) || link.mem_break) && !in_c0;
    wire ret_clr = shallow || force_c0 || (state != pisr_pkg::PS_C2);

    // one hop per cycle; C2 sits between C0 and any deep state both ways
    always_comb begin
        if (break_now) begin
            next_state = pisr_pkg::PS_C2;
        end else if (in_c0 && target > pisr_pkg::PS_C2) begin
            next_state = pisr_pkg::PS_C2;
        end else if (deep_now && target == pisr_pkg::PS_C0) begin
            next_state = pisr_pkg::PS_C2;
        end else begin
            next_state = target;
        end
    end

    // decode of side effects from the state being entered
    wire next_mem_sr = (next_state >= pisr_pkg::PS_C3);
    wire next_bclk_off = (next_state >= pisr_pkg::PS_C6);
    wire next_llc_off = (next_state >= pisr_pkg::PS_C8);
    wire next_llc_flush = next_llc_off && (state < pisr_pkg::PS_C8);
    wire next_crystal_off = (next_state == pisr_pkg::PS_C10);

    genvar g;
    generate
        for (g = 0; g < N_CORES; g = g + 1) begin : g_wake
            always_ff @(posedge ref_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    core_wake[g] <= 1'b0;
                end else begin
                    core_wake[g] <= core_break_i && (break_core_i == CORE_ID_W'(g));
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= pisr_pkg::PSTATE_RST;
        end else begin
            state <= next_state;
        end
    end

    // previous state is kept across a chain of breaks
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev_state <= pisr_pkg::PSTATE_RST;
        end else if (break_now && !returning) begin
            prev_state <= state;
        end
    end

    // set wins over clear so a break in the clearing cycle is kept
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            returning <= 1'b0;
            force_c0 <= 1'b0;
        end else begin
            returning <= ret_set || (returning && !ret_clr);
            force_c0 <= (core_break_i && !break_masked_i) || (force_c0 && !in_c0);
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wake_masked <= 1'b0;
            mem_sr <= 1'b0;
            bclk_off <= 1'b0;
            vr_reduce <= 1'b0;
            llc_flush <= 1'b0;
            llc_off <= 1'b0;
            crystal_off <= 1'b0;
        end else begin
            wake_masked <= core_break_i && break_masked_i;
            mem_sr <= next_mem_sr;
            bclk_off <= next_bclk_off;
            vr_reduce <= next_bclk_off;
            llc_flush <= next_llc_flush;
            llc_off <= next_llc_off;
            crystal_off <= next_crystal_off;
        end
    end

    assign pkg_state_o = state;
    assign core_wake_o = core_wake;
    assign wake_masked_o = wake_masked;
    assign mem_sr_o = mem_sr;
    assign bclk_off_o = bclk_off;
    assign vr_reduce_o = vr_reduce;
    assign llc_flush_o = llc_flush;
    assign llc_off_o = llc_off;
    assign link.pkg_state = state;
    assign link.crystal_off = crystal_off;
endmodule

/* verification/package_idle_state_resolver_tb.sv */
// testbench joining the package end and the platform end through the link
`timescale 1ns/10ps
module package_idle_state_resolver_tb;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [11:0] core_req_i = 12'h000;
    logic gfx_pd_i = 1'b1;
    logic timer_near_i = 1'b0;
    logic autodemote_en_i = 1'b0;
    pisr_pkg::pisr_pstate_t autodemote_cap_i = pisr_pkg::PS_C3;
    logic core_break_i = 1'b0;
    logic [1:0] break_core_i = 2'h0;
    logic break_masked_i = 1'b0;
    pisr_pkg::pisr_pstate_t ltr_cap_i = pisr_pkg::PS_C10;
    logic hold_high_i = 1'b0;
    pisr_pkg::pisr_pstate_t hold_cap_i = pisr_pkg::PS_C3;
    logic mem_req_i = 1'b0;
    logic disp_off_i = 1'b0;
    logic disp_psr_i = 1'b0;
    logic single_panel_i = 1'b0;
    logic panel_psr_cap_i = 1'b0;
    logic vr_deep_i = 1'b0;
    logic xtal_stop_ok_i = 1'b0;
    pisr_pkg::pisr_pstate_t pkg_state_o;
    pisr_pkg::pisr_pstate_t plat_state_o;
    logic [3:0] core_wake_o;
    logic wake_masked_o, mem_sr_o, bclk_off_o, vr_reduce_o, llc_flush_o, llc_off_o;
    logic mem_grant_o, xtal_stopped_o;
    int fail_count = 0;
    int compares = 0;
    int grant_cnt = 0;
    pisr_pkg::pisr_pstate_t exp_tab [4] = '{pisr_pkg::PS_C2, pisr_pkg::PS_C3, pisr_pkg::PS_C3,
                                           pisr_pkg::PS_C0};

    pisr_link_if link();

    pisr_resolver pisr_resolver_i (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .core_req_i(core_req_i), .gfx_pd_i(gfx_pd_i),
        .timer_near_i(timer_near_i), .autodemote_en_i(autodemote_en_i),
        .autodemote_cap_i(autodemote_cap_i), .core_break_i(core_break_i),
        .break_core_i(break_core_i), .break_masked_i(break_masked_i), .pkg_state_o(pkg_state_o),
        .core_wake_o(core_wake_o), .wake_masked_o(wake_masked_o), .mem_sr_o(mem_sr_o),
        .bclk_off_o(bclk_off_o), .vr_reduce_o(vr_reduce_o), .llc_flush_o(llc_flush_o),
        .llc_off_o(llc_off_o), .link(link)
    );

    pisr_platform pisr_platform_i (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ltr_cap_i(ltr_cap_i), .hold_high_i(hold_high_i),
        .hold_cap_i(hold_cap_i), .mem_req_i(mem_req_i), .disp_off_i(disp_off_i),
        .disp_psr_i(disp_psr_i), .single_panel_i(single_panel_i),
        .panel_psr_cap_i(panel_psr_cap_i), .vr_deep_i(vr_deep_i), .xtal_stop_ok_i(xtal_stop_ok_i),
        .pkg_state_o(plat_state_o), .mem_grant_o(mem_grant_o), .xtal_stopped_o(xtal_stopped_o),
        .link(link)
    );

    pisr_link_checker pisr_link_checker_i (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .pkg_state(link.pkg_state),
        .crystal_off(link.crystal_off), .ltr_cap(link.ltr_cap), .hold_high(link.hold_high),
        .hold_cap(link.hold_cap), .mem_break(link.mem_break), .disp_off(link.disp_off),
        .disp_psr(link.disp_psr), .single_panel(link.single_panel),
        .panel_psr_cap(link.panel_psr_cap), .vr_deep(link.vr_deep),
        .xtal_stop_ok(link.xtal_stop_ok)
    );

    always #10 ref_clk_i = ~ref_clk_i;

    // grant is a one-cycle pulse, so a running count shows each service exactly once
    always @(posedge ref_clk_i) grant_cnt <= grant_cnt + int'(mem_grant_o);

    task automatic results();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic hop(input logic [2:0] exp);
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        cmp(12'(pkg_state_o), 12'(exp));
    endtask

    // bounded wait for a state change; running out ends the run
    task automatic wait_state(input logic [2:0] exp);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        while (pkg_state_o !== exp && n < 12) begin
            @(negedge ref_clk_i);
            n++;
        end
        cmp(12'(pkg_state_o), 12'(exp));
        // bound used up without a match: already counted, stop here
        if (pkg_state_o !== exp) results();
    endtask

    task automatic brk(input logic [1:0] id, input logic m);
        @(posedge ref_clk_i);
        core_break_i <= 1'b1;
        break_core_i <= id;
        break_masked_i <= m;
        @(posedge ref_clk_i);
        core_break_i <= 1'b0;
        @(negedge ref_clk_i);
        cmp(12'({core_wake_o, wake_masked_o}), 12'({4'b0001 << id, m}));
        cmp(12'(pkg_state_o), 12'(pisr_pkg::PS_C2));
    endtask

    initial begin
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(negedge ref_clk_i);
        cmp(12'(pkg_state_o), 12'(pisr_pkg::PS_C0));
        cmp({core_wake_o, wake_masked_o, mem_sr_o, bclk_off_o, vr_reduce_o, llc_flush_o,
             llc_off_o, mem_grant_o, xtal_stopped_o}, 12'h000);
        $display("reset values done");
        @(posedge ref_clk_i);
        core_req_i <= {pisr_pkg::CR_C6, pisr_pkg::CR_C8, pisr_pkg::CR_C10, pisr_pkg::CR_C6};
        hop(pisr_pkg::PS_C2);
        hop(pisr_pkg::PS_C6);
        cmp(12'({mem_sr_o, bclk_off_o, vr_reduce_o, llc_off_o}), 12'h00e);
        @(posedge ref_clk_i);
        core_req_i <= {4{pisr_pkg::CR_C8}};
        hop(pisr_pkg::PS_C8);
        cmp(12'({llc_flush_o, llc_off_o}), 12'h003);
        hop(pisr_pkg::PS_C8);
        cmp(12'(llc_flush_o), 12'h000);
        $display("deep entry done");
        @(posedge ref_clk_i);
        core_req_i <= {4{pisr_pkg::CR_C10}};
        disp_psr_i <= 1'b1;
        vr_deep_i <= 1'b1;
        xtal_stop_ok_i <= 1'b1;
        repeat (4) hop(pisr_pkg::PS_C8);
        @(posedge ref_clk_i);
        single_panel_i <= 1'b1;
        panel_psr_cap_i <= 1'b1;
        wait_state(pisr_pkg::PS_C10);
        repeat (2) hop(pisr_pkg::PS_C10);
        cmp(12'(xtal_stopped_o), 12'h001);
        cmp(12'(plat_state_o), 12'(pisr_pkg::PS_C10));
        $display("c10 entry done");
        @(posedge ref_clk_i);
        mem_req_i <= 1'b1;
        @(posedge ref_clk_i);
        mem_req_i <= 1'b0;
        wait_state(pisr_pkg::PS_C2);
        wait_state(pisr_pkg::PS_C10);
        // grant pulse lands in the counter one edge later
        hop(pisr_pkg::PS_C10);
        cmp(12'(grant_cnt), 12'h001);
        @(posedge ref_clk_i);
        hold_high_i <= 1'b1;
        wait_state(pisr_pkg::PS_C3);
        @(posedge ref_clk_i);
        mem_req_i <= 1'b1;
        @(posedge ref_clk_i);
        mem_req_i <= 1'b0;
        wait_state(pisr_pkg::PS_C2);
        wait_state(pisr_pkg::PS_C3);
        repeat (3) hop(pisr_pkg::PS_C3);
        cmp(12'(grant_cnt), 12'h002);
        @(posedge ref_clk_i);
        hold_high_i <= 1'b0;
        wait_state(pisr_pkg::PS_C10);
        $display("memory break done");
        brk(2'h2, 1'b1);
        wait_state(pisr_pkg::PS_C10);
        brk(2'h1, 1'b0);
        @(posedge ref_clk_i);
        core_req_i <= {pisr_pkg::CR_C10, pisr_pkg::CR_C10, pisr_pkg::CR_C0, pisr_pkg::CR_C10};
        @(negedge ref_clk_i);
        cmp(12'(pkg_state_o), 12'(pisr_pkg::PS_C0));
        repeat (3) hop(pisr_pkg::PS_C0);
        $display("core break done");
        for (int v = 0; v < 4; v++) begin
            @(posedge ref_clk_i);
            timer_near_i <= (v == 0);
            autodemote_en_i <= (v == 1);
            ltr_cap_i <= (v == 2) ? pisr_pkg::PS_C3 : pisr_pkg::PS_C10;
            gfx_pd_i <= (v != 3);
            core_req_i <= {4{pisr_pkg::CR_C6}};
            // platform forwards in one cycle, then two hops at most
            repeat (4) @(negedge ref_clk_i);
            cmp(12'(pkg_state_o), 12'(exp_tab[v]));
            @(posedge ref_clk_i);
            core_req_i <= {4{pisr_pkg::CR_C0}};
            repeat (3) @(negedge ref_clk_i);
        end
        $display("constraint table done");
        // display off alone must satisfy the display condition
        @(posedge ref_clk_i);
        gfx_pd_i <= 1'b1;
        core_req_i <= {4{pisr_pkg::CR_C10}};
        disp_psr_i <= 1'b0;
        disp_off_i <= 1'b1;
        wait_state(pisr_pkg::PS_C10);
        $display("display off done");
        results();
    end
endmodule

/* verification/pisr_link_checker.sv */
// concurrent checks on the link between the package end and the platform end
`timescale 1ns/10ps
module pisr_link_checker (
    input wire logic ref_clk_i,                     // clock
    input wire logic nrst_i,                        // async reset, active low
    input wire pisr_pkg::pisr_pstate_t pkg_state,   // package state
    input wire logic crystal_off,                   // crystal stop request
    input wire pisr_pkg::pisr_pstate_t ltr_cap,     // tolerance cap
    input wire logic hold_high,                     // hold request
    input wire pisr_pkg::pisr_pstate_t hold_cap,    // held state
    input wire logic mem_break,                     // memory break pulse
    input wire logic disp_off,                      // display off
    input wire logic disp_psr,                      // display self-refresh
    input wire logic single_panel,                  // single panel
    input wire logic panel_psr_cap,                 // panel self-refresh capable
    input wire logic vr_deep,                       // regulators deep
    input wire logic xtal_stop_ok                   // crystal may stop
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    logic c10_ok;
    // self-refresh only counts on a single capable panel
    assign c10_ok = vr_deep && xtal_stop_ok &&
                    (disp_off || (disp_psr && single_panel && panel_psr_cap));

    chk_state_legal: assert property (pkg_state <= pisr_pkg::PS_C10)
        else $error("package state out of range");
    chk_c0_leave_hop: assert property (
        (pkg_state == pisr_pkg::PS_C0) |=> (pkg_state <= pisr_pkg::PS_C2))
        else $error("package left C0 without passing C2");
    chk_c0_return_hop: assert property (
        (pkg_state > pisr_pkg::PS_C2) |=> (pkg_state != pisr_pkg::PS_C0))
        else $error("deep state went straight to C0");
    chk_ltr_limit: assert property (
        1'b1 |=> (pkg_state <= pisr_pkg::PS_C2 || pkg_state <= $past(ltr_cap)))
        else $error("package deeper than tolerance allows");
    chk_hold_limit: assert property (
        hold_high |=> (pkg_state <= pisr_pkg::PS_C2 || pkg_state <= $past(hold_cap)))
        else $error("package deeper than held state");
    chk_mem_to_c2: assert property (mem_break |=> (pkg_state == pisr_pkg::PS_C2))
        else $error("memory break did not open the memory path");
    chk_mem_pulse: assert property (mem_break |=> !mem_break)
        else $error("memory break longer than one cycle");
    chk_c10_gate: assert property (
        (pkg_state == pisr_pkg::PS_C10) |-> $past(c10_ok))
        else $error("C10 entered without platform conditions");
    chk_crystal_c10: assert property (
        crystal_off |->
        (pkg_state == pisr_pkg::PS_C10 || $past(pkg_state) == pisr_pkg::PS_C10))
        else $error("crystal stop requested outside C10");
endmodule
